// ### common/ext_irq_regs.vh
// Register map, field positions and reset values of the external pin interrupt unit.
// Assumes an 8-bit register port addressed by byte offset.
`ifndef EXT_IRQ_REGS_VH
`define EXT_IRQ_REGS_VH

// Register offsets
`define OFS_EXT_IRQ_FLAGS 8'h3c
`define OFS_EXT_IRQ_ENABLES 8'h3d
`define OFS_SENSE_CONTROL 8'h69
`define OFS_PC_MASK_G0 8'h6b
`define OFS_PC_MASK_G1 8'h6c
`define OFS_PC_MASK_G2 8'h6d
`define OFS_PC_MASK_G3 8'h73

// Field positions in flag and enable registers
`define BIT_DEDICATED 0
`define BIT_GROUP0 4
`define BIT_GROUP1 5
`define BIT_GROUP2 6
`define BIT_GROUP3 7

// Sense control decode
`define SENSE_LOW_LEVEL 2'h0
`define SENSE_ANY_CHANGE 2'h1
`define SENSE_FALLING 2'h2
`define SENSE_RISING 2'h3

// Reset values and widths
`define RST_BYTE 8'h00
`define RST_SENSE 2'h0
`define RST_SRC 5'h00
`define MASK_G3_USED 8'h7f
`define ARM_DONE 2'h3
`define ARM_RST 2'h0
`define ARM_STEP 2'h1

// Group bounds on the pin-change inputs
`define G0_LO 0
`define G0_HI 7
`define G1_LO 8
`define G1_HI 15
`define G2_LO 16
`define G2_HI 23
`define G3_LO 24
`define G3_HI 30

// Sense field and padding
`define SENSE_LO 0
`define SENSE_HI 1
`define SENSE_PAD 6'h00

// Sources present per variant, and an empty change vector
`define SRC_ALL 5'h1f
`define SRC_SMALL 5'h07
`define CHG_NONE 32'h0000_0000

`endif

// ### dv/epiu_properties.sv
// Port checker for the pin interrupt unit.
// Assumes one clock domain, reset high.
`timescale 1ns/10ps
`default_nettype none
module epiu_props #(parameter LARGE_PKG = 1, parameter NUM_PC = 31) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins and core
  input wire logic [NUM_PC-1:0] pin_change_inputs,
  input wire logic global_irq_en,
  input wire logic [4:0] vector_ack,
  input wire logic [4:0] irq_req
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // No change left in the synchroniser
  sequence s_quiet;
    $stable(pin_change_inputs)[*6];
  endsequence
  property p_clr(c, r);
    s_quiet ##0 c |=> ##1 !r;
  endproperty
  AST_RESET: assert property ($fell(reset) |-> irq_req == 5'h00)
    else $error("request after reset");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
  AST_NO_GLOBAL: assert property (!$past(global_irq_en) |-> irq_req == 5'h00)
    else $error("request without global bit");
  AST_W1C: assert property (p_clr(reg_wr && reg_addr == 8'h3c && reg_wdata[4], irq_req[1]))
    else $error("write one kept flag");
  AST_ACK: assert property (p_clr(vector_ack[2], irq_req[2]))
    else $error("acknowledge kept flag");
  AST_STICKY: assert property (irq_req[1] && global_irq_en && !(vector_ack[1] || reg_wr
    || $past(vector_ack[1]) || $past(reg_wr)) |=> irq_req[1])
    else $error("flag lost");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_MASK3: assert property (reg_rd && reg_addr == 8'h73 |=> !reg_rdata[7])
    else $error("reserved mask bit set");
endmodule
bind external_pin_interrupt_unit epiu_props #(.LARGE_PKG(LARGE_PKG), .NUM_PC(NUM_PC)) chk (
  .mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .pin_change_inputs, .global_irq_en, .vector_ack, .irq_req);
`default_nettype wire

// ### dv/external_pin_interrupt_unit_bench.sv
// Self-checking bench for the pin interrupt unit.
// Assumes read data one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module external_pin_interrupt_unit_bench;
  logic mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, gie = 1, rd_d = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic [4:0] vector_ack = 5'h00, irq_req;
  logic [31:0] flip = 32'h0000_0000, pins, seed = 32'h0000_2f3f;
  logic [12:0] expq[$];
  logic [12:0] e;
  logic [7:0] ofs[8] = '{8'h3c, 8'h3d, 8'h69, 8'h6b, 8'h6c, 8'h6d, 8'h73, 8'h00};
  int n_fail = 0, check_count = 0;
  always #25 mclk = ~mclk;
  pin_source src (.mclk(mclk), .flip(flip), .pins(pins));
  external_pin_interrupt_unit dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dedicated_irq_pin(pins[31]), .pin_change_inputs(pins[30:0]),
    .global_irq_en(gie), .vector_ack(vector_ack), .irq_req(irq_req));
  function logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task wr(logic [7:0] a, logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(logic [7:0] a, logic [7:0] v, logic [4:0] i);
    @(posedge mclk);
    expq.push_back({i, v});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task ack(logic [4:0] m);
    @(posedge mclk);
    vector_ack <= m;
    @(posedge mclk);
    vector_ack <= 5'h00;
  endtask
  // Six clocks cover synchroniser and flag latency
  task tog(logic [31:0] m);
    @(posedge mclk);
    flip <= m;
    @(posedge mclk);
    flip <= 32'h0000_0000;
    repeat (6) @(posedge mclk);
  endtask
  task report_and_stop();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
    begin
      e = expq.pop_front();
      check_count++;
      if ({irq_req, reg_rdata} !== e)
      begin
        n_fail++;
        $display("unexpected at %0t got %h exp %h", $time, {irq_req, reg_rdata}, e);
      end
    end
  end
  initial
  begin
    #2000000;
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    foreach (ofs[k]) rd(ofs[k], 8'h00, 5'h00);
    for (int k = 3; k < 7; k++)
    begin
      d = xs();
      wr(ofs[k], d);
      rd(ofs[k], k == 6 ? d & 8'h7f : d, 5'h00);
      wr(ofs[k], 8'hff);
    end
    wr(8'h3d, 8'hff);
    rd(8'h3d, 8'hf1, 5'h00);
    $display("test registers done");
    for (int g = 0; g < 4; g++)
    begin
      tog(32'h1 << (g * 8 + xs() % 7));
      rd(8'h3c, 8'h10 << g, 5'h02 << g);
      if (g[0])
        ack(5'h02 << g);
      else
        wr(8'h3c, 8'h10 << g);
      rd(8'h3c, 8'h00, 5'h00);
    end
    $display("test groups done");
    wr(8'h6b, 8'hfe);
    tog(32'h0000_0001);
    rd(8'h3c, 8'h00, 5'h00);
    wr(8'h3d, 8'hd1);
    tog(32'h0000_0100);
    rd(8'h3c, 8'h00, 5'h00);
    wr(8'h3d, 8'hf1);
    gie <= 1'b0;
    tog(32'h0000_0200);
    rd(8'h3c, 8'h20, 5'h00);
    wr(8'h3c, 8'h20);
    gie <= 1'b1;
    $display("test gating done");
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h69, s[7:0]);
      tog(32'h8000_0000);
      rd(8'h3c, {7'h00, s == 1 || s == 2}, {4'h0, s != 3});
      wr(8'h3c, 8'h01);
      tog(32'h8000_0000);
      rd(8'h3c, {7'h00, s == 1 || s == 3}, {4'h0, s[0]});
      wr(8'h3c, 8'h01);
    end
    $display("test sense done");
    repeat (3) @(posedge mclk);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### dv/pin_source.sv
// Pin source model; bit 31 is the dedicated pin.
// Assumes toggle requests arrive right after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module pin_source (
  // Clock and requests
  input wire logic mclk,
  input wire logic [31:0] flip,
  // Pins, idle high
  output var logic [31:0] pins
);
  initial pins = 32'hffff_ffff;
  // Each level holds many clocks, never a short pulse
  always @(posedge mclk)
  begin
    pins <= pins ^ flip;
  end
endmodule
`default_nettype wire

// ### verilog/external_pin_interrupt_unit.v
// External pin interrupt unit: one dedicated interrupt pin and four pin-change groups.
// Assumes pins are asynchronous to mclk and the core acknowledges vectoring with one-cycle pulses.
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "ext_irq_regs.vh"

module external_pin_interrupt_unit #(
  parameter LARGE_PKG = 1,
  parameter NUM_PC = 31
)
(
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Pins
  input wire dedicated_irq_pin,
  input wire [NUM_PC-1:0] pin_change_inputs,
  // Core side
  input wire global_irq_en,
  input wire [4:0] vector_ack,
  output reg [4:0] irq_req
);

  // Source order: 0 dedicated, 1..4 groups 0..3
  localparam [4:0] SRC_PRESENT = (LARGE_PKG != 0) ? `SRC_ALL : `SRC_SMALL;

  reg ded_meta_q;
  reg ded_sync_q;
  reg ded_prev_q;
  reg [NUM_PC-1:0] pc_meta_q;
  reg [NUM_PC-1:0] pc_sync_q;
  reg [NUM_PC-1:0] pc_prev_q;
  reg [1:0] arm_q;
  reg [4:0] flag_q;
  reg [4:0] flag_d;
  reg [4:0] en_q;
  reg [1:0] sense_q;
  reg [7:0] mask0_q;
  reg [7:0] mask1_q;
  reg [7:0] mask2_q;
  reg [7:0] mask3_q;
  reg [4:0] set_ev;
  reg [4:0] sw_clr;
  reg [4:0] req_d;
  reg [7:0] rdata_d;
  reg ded_event;
  reg [31:0] pc_chg;
  wire armed;
  wire level_mode;
  reg [4:0] clr_all;
  wire wr_flags;
  wire wr_enables;
  wire wr_sense;
  wire wr_mask0;
  wire wr_mask1;
  wire wr_mask2;
  wire wr_mask3;
  wire ded_rise;
  wire ded_fall;
  wire ded_any;
  wire level_req;
  wire [7:0] val_flags;
  wire [7:0] val_enables;
  wire [7:0] val_sense;
  wire [7:0] val_mask0;
  wire [7:0] val_mask1;
  wire [7:0] val_mask2;
  wire [7:0] val_mask3;

  // Sticky flag update; a set in the same cycle beats any clear
  function [4:0] sticky_next;
    input [4:0] cur;
    input [4:0] set;
    input [4:0] clr;
    begin
      sticky_next = set | (cur & ~clr);
    end
  endfunction

  // Pack five source bits into the flag/enable byte layout
  function [7:0] pack_src;
    input [4:0] src;
    begin
      pack_src = `RST_BYTE;
      pack_src[`BIT_DEDICATED] = src[0];
      pack_src[`BIT_GROUP0] = src[1];
      pack_src[`BIT_GROUP1] = src[2];
      pack_src[`BIT_GROUP2] = src[3];
      pack_src[`BIT_GROUP3] = src[4];
    end
  endfunction

  // Unpack the byte layout into source order
  function [4:0] unpack_src;
    input [7:0] b;
    begin
      unpack_src = {b[`BIT_GROUP3], b[`BIT_GROUP2], b[`BIT_GROUP1], b[`BIT_GROUP0],
        b[`BIT_DEDICATED]};
    end
  endfunction

  // One group's request: its enable, then any unmasked change
  function group_hit;
    input en;
    input [7:0] chg;
    input [7:0] mask;
    begin
      group_hit = en & (|(chg & mask));
    end
  endfunction

  // Write strobe aimed at one register offset
  function wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = wr & (addr == ofs);
    end
  endfunction

  // Write decode shared by the flag clear and the register writes
  assign wr_flags = wr_hit(reg_wr, reg_addr, `OFS_EXT_IRQ_FLAGS);
  assign wr_enables = wr_hit(reg_wr, reg_addr, `OFS_EXT_IRQ_ENABLES);
  assign wr_sense = wr_hit(reg_wr, reg_addr, `OFS_SENSE_CONTROL);
  assign wr_mask0 = wr_hit(reg_wr, reg_addr, `OFS_PC_MASK_G0);
  assign wr_mask1 = wr_hit(reg_wr, reg_addr, `OFS_PC_MASK_G1);
  assign wr_mask2 = wr_hit(reg_wr, reg_addr, `OFS_PC_MASK_G2);
  assign wr_mask3 = wr_hit(reg_wr, reg_addr, `OFS_PC_MASK_G3);

  // Dedicated pin synchroniser; level is read whatever the pin direction
  // The previous-value flop turns levels into edges
  always @(posedge mclk)
  begin
    if (reset)
    begin
      ded_meta_q <= 1'b0;
      ded_sync_q <= 1'b0;
      ded_prev_q <= 1'b0;
    end
    else
    begin
      ded_meta_q <= dedicated_irq_pin;
      ded_sync_q <= ded_meta_q;
      ded_prev_q <= ded_sync_q;
    end
  end

  // Pin-change synchroniser; sampled on mclk, so no wake-up without a clock
  always @(posedge mclk)
  begin
    if (reset)
    begin
      pc_meta_q <= {NUM_PC{1'b0}};
      pc_sync_q <= {NUM_PC{1'b0}};
      pc_prev_q <= {NUM_PC{1'b0}};
    end
    else
    begin
      pc_meta_q <= pin_change_inputs;
      pc_sync_q <= pc_meta_q;
      pc_prev_q <= pc_sync_q;
    end
  end

  // Edge detection waits until the pipeline holds real pin levels,
  // so a pin already high at reset release is not seen as a change.
  always @(posedge mclk)
  begin
    if (reset)
      arm_q <= `ARM_RST;
    else if (arm_q != `ARM_DONE)
      arm_q <= arm_q + `ARM_STEP;
  end

  assign armed = (arm_q == `ARM_DONE);
  assign level_mode = (sense_q == `SENSE_LOW_LEVEL);

  // Edge kinds of the dedicated pin, quiet until armed
  assign ded_rise = armed & ~ded_prev_q & ded_sync_q;
  assign ded_fall = armed & ded_prev_q & ~ded_sync_q;
  assign ded_any = ded_rise | ded_fall;

  // Sense decode; low level has no flag, its request comes from the pin
  always @*
  begin
    case (sense_q)
      `SENSE_ANY_CHANGE: ded_event = ded_any;
      `SENSE_FALLING: ded_event = ded_fall;
      `SENSE_RISING: ded_event = ded_rise;
      default: ded_event = 1'b0;
    endcase
  end

  // Pin-change events per group; mask3 bit 7 is always zero
  always @*
  begin
    pc_chg = `CHG_NONE;
    pc_chg[NUM_PC-1:0] = armed ? (pc_sync_q ^ pc_prev_q) : {NUM_PC{1'b0}};
    set_ev[0] = ded_event;
    set_ev[1] = group_hit(en_q[1], pc_chg[`G0_HI:`G0_LO], mask0_q);
    set_ev[2] = group_hit(en_q[2], pc_chg[`G1_HI:`G1_LO], mask1_q);
    set_ev[3] = group_hit(en_q[3], pc_chg[`G2_HI:`G2_LO], mask2_q);
    set_ev[4] = group_hit(en_q[4], {1'b0, pc_chg[`G3_HI:`G3_LO]}, mask3_q);
    set_ev = set_ev & SRC_PRESENT;
  end

  // Flag next state
  always @*
  begin
    sw_clr = `RST_SRC;
    if (wr_flags)
      sw_clr = unpack_src(reg_wdata);
    clr_all = sw_clr | vector_ack;
    flag_d = sticky_next(flag_q, set_ev, clr_all);
    if (level_mode)
      flag_d[0] = 1'b0;
    flag_d = flag_d & SRC_PRESENT;
  end

  // Level mode requests straight from the synced pin, so it follows the pin
  assign level_req = ~ded_sync_q & en_q[0] & global_irq_en;

  // Requests towards the core
  always @*
  begin
    req_d = flag_q & en_q & {5{global_irq_en}};
    if (level_mode)
      req_d[0] = level_req;
  end

  // Read values; reserved bits and absent groups read zero
  assign val_flags = pack_src(flag_q);
  assign val_enables = pack_src(en_q);
  assign val_sense = {`SENSE_PAD, sense_q};
  assign val_mask0 = mask0_q;
  assign val_mask1 = mask1_q;
  assign val_mask2 = mask2_q;
  assign val_mask3 = mask3_q;

  // Read mux; unmapped offsets read zero
  always @*
  begin
    rdata_d = `RST_BYTE;
    if (reg_rd)
    begin
      case (reg_addr)
        `OFS_EXT_IRQ_FLAGS: rdata_d = val_flags;
        `OFS_EXT_IRQ_ENABLES: rdata_d = val_enables;
        `OFS_SENSE_CONTROL: rdata_d = val_sense;
        `OFS_PC_MASK_G0: rdata_d = val_mask0;
        `OFS_PC_MASK_G1: rdata_d = val_mask1;
        `OFS_PC_MASK_G2: rdata_d = val_mask2;
        `OFS_PC_MASK_G3: rdata_d = val_mask3;
        default: rdata_d = `RST_BYTE;
      endcase
    end
  end

  // Sticky flags
  always @(posedge mclk)
  begin
    if (reset)
      flag_q <= `RST_SRC;
    else
      flag_q <= flag_d;
  end

  // Requests registered so the core never sees a decode glitch
  always @(posedge mclk)
  begin
    if (reset)
      irq_req <= `RST_SRC;
    else
      irq_req <= req_d;
  end

  // Read data stands for one cycle only, zero otherwise
  always @(posedge mclk)
  begin
    if (reset)
      reg_rdata <= `RST_BYTE;
    else
      reg_rdata <= rdata_d;
  end

  // Enables; absent groups stay off
  always @(posedge mclk)
  begin
    if (reset)
      en_q <= `RST_SRC;
    else if (wr_enables)
      en_q <= unpack_src(reg_wdata) & SRC_PRESENT;
  end

  // Sense control
  always @(posedge mclk)
  begin
    if (reset)
      sense_q <= `RST_SENSE;
    else if (wr_sense)
      sense_q <= reg_wdata[`SENSE_HI:`SENSE_LO];
  end

  // Mask group 0
  always @(posedge mclk)
  begin
    if (reset)
      mask0_q <= `RST_BYTE;
    else if (wr_mask0)
      mask0_q <= reg_wdata;
  end

  // Mask group 1
  always @(posedge mclk)
  begin
    if (reset)
      mask1_q <= `RST_BYTE;
    else if (wr_mask1)
      mask1_q <= reg_wdata;
  end

  // Mask group 2, missing on the small variant
  always @(posedge mclk)
  begin
    if (reset)
      mask2_q <= `RST_BYTE;
    else if (wr_mask2 && LARGE_PKG != 0)
      mask2_q <= reg_wdata;
  end

  // Mask group 3, missing on the small variant; bit 7 reserved
  always @(posedge mclk)
  begin
    if (reset)
      mask3_q <= `RST_BYTE;
    else if (wr_mask3 && LARGE_PKG != 0)
      mask3_q <= reg_wdata & `MASK_G3_USED;
  end

endmodule
`default_nettype wire
